// *** verilog/pxbs_status.sv ***
// Purpose: primary-side bridge status word with device number capture
// Assumes: requests and events are synchronous to sys_clk
// Notes:   reads answer one cycle after the request
//
// Overview of operation
// - each configuration write to us loads device number from AD[15:11].
// - we are addressed by config command, IDSEL, type 0 and matching function.
// - bits 15:8 mirror the primary bus number, reset all ones.
// - completer ID is built from bus, device and function numbers.
// - bits 16 and 17 are read-only capability bits, reset zero.
// - bit 19 sets on unexpected completion to our ID; write one clears.
// - bit 21 sets when a split request is delayed; write one clears.
// - bits 2:0 hold the read-only function number, reset to the FUNC_NUM strap.
`timescale 1ns/100ps

module pxbs_status #(
  parameter logic [2:0] FUNC_NUM = pxbs_pkg::FUNC_RST
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        req_valid,
  input  wire logic [3:0]  req_cmd,
  input  wire logic        req_idsel,
  input  wire logic [31:0] req_addr,
  input  wire logic [3:0]  req_be,
  input  wire logic [31:0] req_wdata,
  input  wire logic [7:0]  pri_bus_num,
  input  wire logic        unexp_cpl,
  input  wire logic [15:0] unexp_req_id,
  input  wire logic        split_delayed,
  output logic             rd_valid_r,
  output logic [31:0]      rd_data_r,
  output logic [15:0]      cpl_id_r
);
  // ***********************************************************
  // decode
  // ***********************************************************
  logic        [4:0]  dev_num_r;
  logic        [7:0]  bus_num_r;
  logic        [2:0]  func_num_r;
  logic               unexp_r;
  logic               delay_r;
  wire logic          wr_hit;
  wire logic          rd_hit;
  wire logic          stat_sel;
  wire logic          flag_wr;
  wire logic          unexp_clr;
  wire logic          delay_clr;
  wire logic          unexp_set;
  wire logic          unexp_nxt;
  wire logic          delay_nxt;
  wire logic [15:0]   own_id;
  wire logic [31:0]   stat_word;

  pxbs_cfg_decode u_dec (
    .req_valid (req_valid),
    .req_cmd   (req_cmd),
    .req_idsel (req_idsel),
    .req_addr  (req_addr),
    .func_num  (func_num_r),
    .wr_hit    (wr_hit),
    .rd_hit    (rd_hit),
    .stat_sel  (stat_sel)
  );

  assign own_id    = {bus_num_r, dev_num_r, func_num_r};
  assign flag_wr   = wr_hit && stat_sel && req_be[pxbs_pkg::BE_FLAGS];
  assign unexp_clr = flag_wr && req_wdata[pxbs_pkg::UNEXP_POS];
  assign delay_clr = flag_wr && req_wdata[pxbs_pkg::DELAY_POS];
  assign unexp_set = unexp_cpl && (unexp_req_id == own_id);
  // set beats clear so an event in the clearing cycle survives
  assign unexp_nxt = unexp_set || (unexp_r && !unexp_clr);
  assign delay_nxt = split_delayed || (delay_r && !delay_clr);

  // reserved bits 31:22, 20 and 18 read as zero
  assign stat_word = {10'h000, delay_r, 1'h0, unexp_r, 1'h0,
                      pxbs_pkg::MHZ133_RST, pxbs_pkg::BIT64_RST,
                      bus_num_r, dev_num_r, func_num_r};

  // ***********************************************************
  // state
  // ***********************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dev_num_r  <= pxbs_pkg::DEV_RST;
      bus_num_r  <= pxbs_pkg::BUS_RST;
      // strapped value from reset on, so the first request after release decodes
      func_num_r <= FUNC_NUM;
      unexp_r    <= pxbs_pkg::FLAG_RST;
      delay_r    <= pxbs_pkg::FLAG_RST;
      rd_valid_r <= 1'h0;
      rd_data_r  <= 32'h0000_0000;
      cpl_id_r   <= {pxbs_pkg::BUS_RST, pxbs_pkg::DEV_RST, FUNC_NUM};
    end else if (clk_en) begin
      // captured on any register, not only this one
      if (wr_hit) begin
        dev_num_r <= req_addr[pxbs_pkg::AD_DEV_LSB +: 5];
      end
      bus_num_r  <= pri_bus_num;
      func_num_r <= FUNC_NUM;
      unexp_r    <= unexp_nxt;
      delay_r    <= delay_nxt;
      rd_valid_r <= rd_hit;
      rd_data_r  <= (rd_hit && stat_sel) ? stat_word : 32'h0000_0000;
      cpl_id_r   <= own_id;
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  property p_dev_capture;
    @(posedge sys_clk) disable iff (reset)
    (clk_en && wr_hit) |=> (dev_num_r == $past(req_addr[15:11]));
  endproperty
  a_dev_capture: assert property (p_dev_capture)
    else $error("device number not captured");

  property p_no_capture_wrong_func;
    @(posedge sys_clk) disable iff (reset)
    (req_valid && req_addr[10:8] != func_num_r) |=> $stable(dev_num_r);
  endproperty
  a_no_capture_wrong_func: assert property (p_no_capture_wrong_func)
    else $error("device number changed on foreign function");

  property p_bus_mirror;
    @(posedge sys_clk) disable iff (reset)
    (clk_en && !reset) |=> (bus_num_r == $past(pri_bus_num));
  endproperty
  a_bus_mirror: assert property (p_bus_mirror)
    else $error("bus number mirror stale");

  property p_cpl_id;
    @(posedge sys_clk) disable iff (reset)
    (clk_en && !reset) |=>
      (cpl_id_r == {$past(bus_num_r), $past(dev_num_r), $past(func_num_r)});
  endproperty
  a_cpl_id: assert property (p_cpl_id)
    else $error("completer id wrong");

  property p_cap_bits;
    @(posedge sys_clk) disable iff (reset)
    rd_valid_r |-> (rd_data_r[17:16] == 2'h0 && rd_data_r[31:22] == 10'h000);
  endproperty
  a_cap_bits: assert property (p_cap_bits)
    else $error("fixed bits read wrong");

  property p_unexp_set;
    @(posedge sys_clk) disable iff (reset)
    (clk_en && unexp_cpl && unexp_req_id == own_id) |=> unexp_r;
  endproperty
  a_unexp_set: assert property (p_unexp_set)
    else $error("unexpected completion flag not set");

  property p_delay_set;
    @(posedge sys_clk) disable iff (reset)
    (clk_en && split_delayed) |=> delay_r [*1] ##0 1'b1;
  endproperty
  a_delay_set: assert property (p_delay_set)
    else $error("split delayed flag not set");

  property p_func_fixed;
    @(posedge sys_clk) disable iff (reset)
    (func_num_r == FUNC_NUM) && (cpl_id_r[2:0] == FUNC_NUM);
  endproperty
  a_func_fixed: assert property (p_func_fixed)
    else $error("function number changed");

  property p_zero_write_keeps;
    @(posedge sys_clk) disable iff (reset)
    (clk_en && delay_r && !split_delayed && flag_wr && !req_wdata[21]) |=> delay_r;
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps)
    else $error("zero write cleared a flag");

  property p_unexp_clr;
    @(posedge sys_clk) disable iff (reset)
    (clk_en && unexp_clr && !unexp_set) |=> !unexp_r;
  endproperty
  a_unexp_clr: assert property (p_unexp_clr)
    else $error("unexpected completion flag not cleared");

  property p_delay_clr;
    @(posedge sys_clk) disable iff (reset)
    (clk_en && delay_clr && !split_delayed) |=> !delay_r;
  endproperty
  a_delay_clr: assert property (p_delay_clr)
    else $error("split delayed flag not cleared");

  property p_foreign_id;
    @(posedge sys_clk) disable iff (reset)
    (clk_en && unexp_cpl && (unexp_req_id != own_id) && !unexp_r) |=> !unexp_r;
  endproperty
  a_foreign_id: assert property (p_foreign_id)
    else $error("flag set by completion for another id");

  property p_rd_answer;
    @(posedge sys_clk) disable iff (reset)
    (clk_en && rd_hit) |=> rd_valid_r;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("addressed read not answered");

  property p_no_answer;
    @(posedge sys_clk) disable iff (reset)
    (clk_en && !rd_hit) |=> !rd_valid_r;
  endproperty
  a_no_answer: assert property (p_no_answer)
    else $error("read answered without being addressed");

  property p_rd_word;
    @(posedge sys_clk) disable iff (reset)
    (clk_en && rd_hit && stat_sel) |=>
      (rd_data_r[15:0] == {$past(bus_num_r), $past(dev_num_r), FUNC_NUM});
  endproperty
  a_rd_word: assert property (p_rd_word)
    else $error("status word id fields wrong");

  property p_rd_other;
    @(posedge sys_clk) disable iff (reset)
    (clk_en && rd_hit && !stat_sel) |=> (rd_data_r == 32'h0000_0000);
  endproperty
  a_rd_other: assert property (p_rd_other)
    else $error("other register read not zero");

  c_dev_write:  cover property (@(posedge sys_clk) disable iff (reset) wr_hit ##1 rd_valid_r);
  c_unexp_clr:  cover property (@(posedge sys_clk) disable iff (reset) unexp_r ##1 !unexp_r);
  c_set_vs_clr: cover property (@(posedge sys_clk) disable iff (reset) split_delayed && delay_clr);
  c_clk_hold:   cover property (@(posedge sys_clk) disable iff (reset) !clk_en ##1 clk_en);
endmodule

// *** verilog/pxbs_pkg.sv ***
// Purpose: constants of the bridge primary status word, and the
//          configuration request decoder
// Assumes: one configuration request is offered per cycle, as a whole
// Notes:   the decoder is purely combinational
package pxbs_pkg;
  // ***********************************************************
  // register location and bus commands
  // ***********************************************************
  localparam logic [7:0] STAT_OFFSET  = 8'h84;
  localparam logic [3:0] CMD_CFG_RD   = 4'hA;
  localparam logic [3:0] CMD_CFG_WR   = 4'hB;
  localparam logic [1:0] CFG_TYPE0    = 2'h0;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int FUNC_LSB    = 0;
  localparam int DEV_LSB     = 3;
  localparam int BUS_LSB     = 8;
  localparam int BIT64_POS   = 16;
  localparam int MHZ133_POS  = 17;
  localparam int UNEXP_POS   = 19;
  localparam int DELAY_POS   = 21;
  localparam int AD_FUNC_LSB = 8;
  localparam int AD_DEV_LSB  = 11;
  localparam int BE_FLAGS    = 2;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [2:0] FUNC_RST   = 3'h0;
  localparam logic [4:0] DEV_RST    = 5'h1F;
  localparam logic [7:0] BUS_RST    = 8'hFF;
  localparam logic       FLAG_RST   = 1'h0;
  localparam logic       BIT64_RST  = 1'h0;
  localparam logic       MHZ133_RST = 1'h0;
endpackage

`timescale 1ns/100ps

// ***********************************************************
// configuration request decoder
// ***********************************************************
module pxbs_cfg_decode (
  input  wire logic        req_valid,
  input  wire logic [3:0]  req_cmd,
  input  wire logic        req_idsel,
  input  wire logic [31:0] req_addr,
  input  wire logic [2:0]  func_num,
  output wire logic        wr_hit,
  output wire logic        rd_hit,
  output wire logic        stat_sel
);
  wire logic type0_match;

  // idsel, type 0 and our function number must all line up
  assign type0_match = req_valid && req_idsel
                       && (req_addr[1:0] == pxbs_pkg::CFG_TYPE0)
                       && (req_addr[pxbs_pkg::AD_FUNC_LSB +: 3] == func_num);
  assign wr_hit   = type0_match && (req_cmd == pxbs_pkg::CMD_CFG_WR);
  assign rd_hit   = type0_match && (req_cmd == pxbs_pkg::CMD_CFG_RD);
  assign stat_sel = (req_addr[7:2] == pxbs_pkg::STAT_OFFSET[7:2]);
endmodule

// *** testbench/pxbs_cfg_master.sv ***
// Purpose: configuration master on the primary bus, one request at a time
// Assumes: requests launch just after a rising edge and last one cycle
// Notes:   idle lines show the inverse of the last value, so stale values never match
`timescale 1ns/100ps

module pxbs_cfg_master (
  input  wire logic        sys_clk,
  output logic             req_valid,
  output logic [3:0]       req_cmd,
  output logic             req_idsel,
  output logic [31:0]      req_addr,
  output logic [3:0]       req_be,
  output logic [31:0]      req_wdata
);
  initial begin
    req_valid = 1'h0;
    {req_cmd, req_idsel, req_addr, req_be, req_wdata} = '0;
  end

  // idsel travels with the address phase of the same request
  task automatic xfer(input logic [3:0] cmd, input logic sel, input logic [31:0] addr,
                      input logic [3:0] be, input logic [31:0] wd);
    @(posedge sys_clk);
    req_valid <= 1'h1;
    {req_cmd, req_idsel, req_addr, req_be, req_wdata} <= {cmd, sel, addr, be, wd};
    @(posedge sys_clk);
    req_valid <= 1'h0;
    {req_cmd, req_idsel, req_addr, req_be, req_wdata} <= ~{cmd, sel, addr, be, wd};
  endtask
endmodule

// *** testbench/pxbs_status_bench.sv ***
// Purpose: self-checking bench of the bridge primary status word
// Assumes: reads answer one cycle after the request
// Notes:   expected read words queue up; a monitor takes them off in order
`timescale 1ns/100ps

module pxbs_status_bench;
  logic        sys_clk   = 1'h0;
  logic        reset     = 1'h1;
  logic        clk_en    = 1'h1;
  logic [7:0]  bus_num   = 8'h00;
  logic        unexp_cpl = 1'h0;
  logic [15:0] unexp_id  = 16'h0000;
  logic        split_dly = 1'h0;
  logic [15:0] lfsr      = 16'h2B0C;
  logic [4:0]  dev       = 5'h1F;
  logic [31:0] exp_q[$];
  int          fail_count = 0;
  int          n_compared = 0;
  wire logic        req_valid, req_idsel, rd_valid_r;
  wire logic [3:0]  req_cmd, req_be;
  wire logic [31:0] req_addr, req_wdata, rd_data_r;
  wire logic [15:0] cpl_id_r;

  pxbs_cfg_master mst_u (.sys_clk(sys_clk), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_idsel(req_idsel), .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata));
  pxbs_status #(.FUNC_NUM(3'h5)) dut_u (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_idsel(req_idsel), .req_addr(req_addr),
    .req_be(req_be), .req_wdata(req_wdata), .pri_bus_num(bus_num), .unexp_cpl(unexp_cpl),
    .unexp_req_id(unexp_id), .split_delayed(split_dly), .rd_valid_r(rd_valid_r),
    .rd_data_r(rd_data_r), .cpl_id_r(cpl_id_r));

  initial forever #4 sys_clk = ~sys_clk;

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] word(input logic f19, input logic f21);
    return {10'h000, f21, 1'h0, f19, 3'h0, bus_num, dev, 3'h5};
  endfunction
  // type 0 address: device, function, dword, type
  function automatic logic [31:0] mk(input logic [4:0] d, input logic [2:0] f,
                                     input logic [5:0] dw, input logic [1:0] t);
    return {16'h0000, d, f, dw, t};
  endfunction

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_id(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: completer id %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] dw, input logic [31:0] exp);
    exp_q.push_back(exp);
    mst_u.xfer(pxbs_pkg::CMD_CFG_RD, 1'h1, mk(5'h00, 3'h5, dw, 2'h0), 4'hF, 32'h0);
  endtask
  task automatic wr84(input logic [3:0] be, input logic [31:0] wd);
    mst_u.xfer(pxbs_pkg::CMD_CFG_WR, 1'h1, mk(dev, 3'h5, 6'h21, 2'h0), be, wd);
  endtask
  task automatic pulse(input logic u, input logic s, input logic [15:0] id);
    @(posedge sys_clk);
    {unexp_cpl, split_dly, unexp_id} <= {u, s, id};
    @(posedge sys_clk);
    {unexp_cpl, split_dly} <= 2'h0;
  endtask
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // a read answer with nothing queued compares against unknown and fails
  always @(negedge sys_clk) begin
    if (rd_valid_r === 1'h1) check_word(rd_data_r, exp_q.size() ? exp_q.pop_front() : 'x);
  end

  initial begin
    #40000;
    fail_count++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    lfsr = lfsr_next(lfsr);
    reset <= 1'h0;
    bus_num <= lfsr[7:0];
    @(posedge sys_clk);
    rd(6'h21, word(1'h0, 1'h0));
    @(negedge sys_clk);
    check_id(cpl_id_r, {bus_num, dev, 3'h5});
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      mst_u.xfer(i == 0 ? 4'h7 : pxbs_pkg::CMD_CFG_WR, i != 1, mk(lfsr[4:0],
        i == 3 ? 3'h2 : 3'h5, 6'h21, i == 2 ? 2'h1 : 2'h0), 4'hF, 32'hFFFFFFFF);
    end
    // a read to another function must get no answer; the monitor catches one
    mst_u.xfer(pxbs_pkg::CMD_CFG_RD, 1'h1, mk(5'h00, 3'h2, 6'h21, 2'h0), 4'hF, 32'h0);
    rd(6'h21, word(1'h0, 1'h0));
    lfsr = lfsr_next(lfsr);
    dev = lfsr[4:0];
    mst_u.xfer(pxbs_pkg::CMD_CFG_WR, 1'h1, mk(dev, 3'h5, 6'h10, 2'h0), 4'hF, 32'h0);
    rd(6'h10, 32'h0);
    rd(6'h21, word(1'h0, 1'h0));
    @(negedge sys_clk);
    check_id(cpl_id_r, {bus_num, dev, 3'h5});
    pulse(1'h1, 1'h0, {bus_num, dev ^ 5'h01, 3'h5});
    rd(6'h21, word(1'h0, 1'h0));
    pulse(1'h1, 1'h1, {bus_num, dev, 3'h5});
    rd(6'h21, word(1'h1, 1'h1));
    wr84(4'hF, 32'h0);
    wr84(4'hB, 32'hFFFFFFFF);
    rd(6'h21, word(1'h1, 1'h1));
    wr84(4'h4, 32'hFFFFFFFF);
    rd(6'h21, word(1'h0, 1'h0));
    // events while the enable is low are lost, not held
    @(posedge sys_clk);
    clk_en <= 1'h0;
    pulse(1'h1, 1'h1, {bus_num, dev, 3'h5});
    clk_en <= 1'h1;
    rd(6'h21, word(1'h0, 1'h0));
    // an event in the clearing cycle survives the clear
    fork
      pulse(1'h0, 1'h1, 16'h0000);
      wr84(4'h4, 32'hFFFFFFFF);
    join
    rd(6'h21, word(1'h0, 1'h1));
    // mid-run reset: flags clear, device number back to all ones
    @(posedge sys_clk);
    reset <= 1'h1;
    @(posedge sys_clk);
    reset <= 1'h0;
    dev = 5'h1F;
    rd(6'h21, word(1'h0, 1'h0));
    @(negedge sys_clk);
    check_id(cpl_id_r, {bus_num, dev, 3'h5});
    repeat (3) @(posedge sys_clk);
    check_word(32'(exp_q.size()), 32'h0);
    final_report();
  end
endmodule
